// ==== core/mce_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the execution core
`ifndef MCE_CONSTS_SVH
`define MCE_CONSTS_SVH

// APB register byte offsets
`define MCE_REG_CMD     8'h00
`define MCE_REG_STATUS  8'h04
`define MCE_REG_ACC     8'h08
`define MCE_REG_PC      8'h0c
`define MCE_REG_TABLE_HIGH_BYTE    8'h10
`define MCE_REG_TBLP    8'h14
`define MCE_REG_DADDR   8'h18
`define MCE_REG_DDATA   8'h1c
`define MCE_REG_PADDR   8'h20
`define MCE_REG_PDATA   8'h24
`define MCE_REG_WDT     8'h28
`define MCE_REG_CYCLES  8'h2c
`define MCE_REG_CTRL    8'h30
`define MCE_REG_STACK   8'h34

// Status register bit positions
`define MCE_ST_BUSY     0
`define MCE_ST_HALTED   1
`define MCE_ST_FLAGS    2
`define MCE_ST_REC1     8
`define MCE_ST_REC2     9

// Control register bit positions
`define MCE_CTRL_WAKE   0
`define MCE_CTRL_WDTEN  1

// Data memory location that aliases the program-counter low byte
`define MCE_PCL_ADDR    6'h06

// Reset values
`define MCE_ACC_RST     8'h00
`define MCE_PC_RST      13'h0000
`define MCE_CTRL_RST    2'h0

// Timing: system clocks per instruction cycle, and base cycle counts
`define MCE_SYS_CLKS_PER_CYCLE 4
`define MCE_DIV_LAST    2'h3
`define MCE_CYC_ONE     3'h1
`define MCE_CYC_TWO     3'h2

`endif

// ==== core/mce_pkg.sv ====
// Types shared by the execution core: opcodes, states, instruction and flag carriers
package mce_pkg;

    typedef enum logic [5:0] {
        MCE_NOP    = 6'h00, MCE_JMP    = 6'h01, MCE_CALL   = 6'h02, MCE_RET   = 6'h03,
        MCE_RETA   = 6'h04, MCE_RETURN_FROM_INTERRUPT   = 6'h05, MCE_SZ     = 6'h06, MCE_SZA   = 6'h07,
        MCE_SZB    = 6'h08, MCE_SNZB   = 6'h09, MCE_SIZ    = 6'h0a, MCE_SDZ   = 6'h0b,
        MCE_INC_SKIP_ZERO_TO_ACC   = 6'h0c, MCE_DEC_SKIP_ZERO_TO_ACC   = 6'h0d, MCE_TRDC   = 6'h0e, MCE_TRDL  = 6'h0f,
        MCE_CLRM   = 6'h10, MCE_SETM   = 6'h11, MCE_CLRB   = 6'h12, MCE_CLRWD = 6'h13,
        MCE_WDPRE1 = 6'h14, MCE_WDPRE2 = 6'h15, MCE_SWAP   = 6'h16, MCE_NIBBLE_SWAP_TO_ACC = 6'h17,
        MCE_HALT   = 6'h18, MCE_ADC    = 6'h19, MCE_ADD_CARRY_TO_MEMORY   = 6'h1a, MCE_ADD   = 6'h1b,
        MCE_ADDI   = 6'h1c, MCE_ADD_TO_MEMORY   = 6'h1d, MCE_ANDA   = 6'h1e, MCE_ANDI  = 6'h1f,
        MCE_AND_TO_MEMORY   = 6'h20
    } mce_op_t;

    typedef enum logic [1:0] {
        MCE_IDLE   = 2'b00,
        MCE_BUSY   = 2'b01,
        MCE_HALTED = 2'b11
    } mce_state_t;

    typedef struct packed {
        mce_op_t     op;
        logic [2:0]  bsel;
        logic [6:0]  maddr;
        logic [15:0] arg;
    } mce_instr_t;

    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } mce_flags_t;

endpackage

// ==== core/mce_core.sv ====
// Instruction execution core subset with an APB register port
`timescale 1ns/1ps
`include "mce_consts.svh"

// How it works
// - a conditional skip takes one cycle, plus one more when the skip is taken.
// - writing the program-counter low byte adds one cycle of four system clocks.
// - memory inc/dec-and-skip writes back, skips on zero; both penalties may apply.
// - accumulator inc/dec-and-skip loads the accumulator, one cycle plus one on skip.
// - jump, call, return, return-with-immediate, interrupt return take two cycles.
// - a call pushes the next address, then loads the target into the counter.
// - table reads fetch a word, low byte to memory, high byte to table-high.
// - add with carry sums accumulator, operand and carry; updates four flags.
// - memory-destination adds write the sum to memory with the same flags.
// - immediate add adds an 8-bit constant to the accumulator, four flags.
// - every AND form changes only the zero flag.
// - clear-memory writes zeros, set-memory writes ones, no flag changes.
// - bit-clear zeros only the bit picked by a 3-bit index, no flags.
// - the watchdog clear zeroes the counter and clears both flags in one cycle.
// - a pre-clear clears the two flags only when the watchdog is cleared.
// - nibble swap exchanges halves; the accumulator form writes to the accumulator.
// - the watchdog clears only after both pre-clears; one alone is only recorded.
// - power-down stops execution, keeps state, sets power-down, clears time-out.
// - power-down also clears the watchdog counter and its prescaler.
module mce_core #(
    parameter int PC_W        = 13,
    parameter int DM_AW       = 6,
    parameter int PM_AW       = 9,
    parameter int STACK_DEPTH = 16,
    parameter int WDT_W       = 8,
    parameter int WDT_PRE_W   = 8
) (
    // Clock and reset
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    // APB slave
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [7:0]  paddr,
    input  wire  logic [31:0] pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr
);
    import mce_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int PG_W = PM_AW - 8;

    ////////////////////////////////////////////////////////////////////////////////
    // State
    mce_state_t       state;
    mce_instr_t       ins_q;
    mce_flags_t       flags;
    logic [7:0]       acc;
    logic [PC_W-1:0]  pc;
    logic [7:0]       table_high_byte;
    logic [7:0]       tbl_ptr;
    logic [DM_AW-1:0] dm_ptr;
    logic [PM_AW-1:0] pm_ptr;
    logic [WDT_W-1:0] watchdog_counter;
    logic [WDT_PRE_W-1:0] wdt_pre;
    logic             wdt_en;
    logic             rec1;
    logic             rec2;
    logic [1:0]       div;
    logic [2:0]       cyc_left;
    logic [2:0]       cyc_last;
    logic [SP_W-1:0]  sp;
    logic [7:0]       dmem [2**DM_AW];
    logic [15:0]      pmem [2**PM_AW];
    logic [PC_W-1:0]  stack [STACK_DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire              acc_phase = psel & penable & pready;
    wire              bus_wr    = acc_phase & pwrite;
    wire              idle      = (state == MCE_IDLE);
    wire              wr_cmd    = bus_wr & (paddr == `MCE_REG_CMD);
    wire              go        = wr_cmd & idle;
    wire              wr_ctrl   = bus_wr & (paddr == `MCE_REG_CTRL);
    wire              host_wr   = bus_wr & idle;
    wire              wr_acc    = host_wr & (paddr == `MCE_REG_ACC);
    wire              wr_pc     = host_wr & (paddr == `MCE_REG_PC);
    wire              wr_tblp   = host_wr & (paddr == `MCE_REG_TBLP);
    wire              wr_daddr  = host_wr & (paddr == `MCE_REG_DADDR);
    wire              wr_ddata  = host_wr & (paddr == `MCE_REG_DDATA);
    wire              wr_paddr  = host_wr & (paddr == `MCE_REG_PADDR);
    wire              wr_pdata  = host_wr & (paddr == `MCE_REG_PDATA);
    wire              tick      = (div == `MCE_DIV_LAST);
    wire mce_instr_t  ins       = mce_instr_t'(pwdata);

    ////////////////////////////////////////////////////////////////////////////////
    // Operand fetch and datapath
    wire [DM_AW-1:0]  maddr   = ins.maddr[DM_AW-1:0];
    wire              m_is_pcl = (maddr == `MCE_PCL_ADDR);
    wire [7:0]        mval    = m_is_pcl ? pc[7:0] : dmem[maddr];
    wire [7:0]        imm     = ins.arg[7:0];
    wire              use_imm = (ins.op == MCE_ADDI) | (ins.op == MCE_ANDI);
    wire [7:0]        opnd    = use_imm ? imm : mval;
    wire              cin     = ((ins.op == MCE_ADC) | (ins.op == MCE_ADD_CARRY_TO_MEMORY)) & flags.carry_flag;
    wire [8:0]        sum9    = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
    wire [4:0]        nib5    = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    wire              add_ov  = (acc[7] == opnd[7]) & (sum9[7] != acc[7]);
    wire [7:0]        and_res = acc & opnd;
    wire [7:0]        inc_v   = mval + 8'h01;
    wire [7:0]        dec_v   = mval - 8'h01;
    wire [7:0]        swp_v   = {mval[3:0], mval[7:4]};
    wire [7:0]        bit_msk = 8'h01 << ins.bsel;
    wire              bit_v   = mval[ins.bsel];
    wire [PG_W-1:0]   cur_pg  = pc[PM_AW-1:8];
    wire [PM_AW-1:0]  tab_cur = {cur_pg, tbl_ptr};
    wire [PM_AW-1:0]  tab_last = {{PG_W{1'b1}}, tbl_ptr};
    wire [PC_W-1:0]   pc_inc  = pc + PC_W'(1);
    wire [SP_W-1:0]   sp_dec  = sp - SP_W'(1);

    ////////////////////////////////////////////////////////////////////////////////
    // Execution decode
    logic [PC_W-1:0]  next_pc;
    logic [7:0]       next_acc;
    logic             acc_we;
    logic             mem_we;
    logic [7:0]       mem_wd;
    mce_flags_t       next_flags;
    logic             skip;
    logic [2:0]       base_cyc;
    logic             push;
    logic             pop;
    logic             table_high_byte_we;
    logic [7:0]       table_high_byte_wd;
    logic             halt;
    logic             wdt_clr;
    logic             next_rec1;
    logic             next_rec2;

    always_comb begin
        next_pc    = pc_inc;
        next_acc   = acc;
        acc_we     = 1'b0;
        mem_we     = 1'b0;
        mem_wd     = mval;
        next_flags = flags;
        skip       = 1'b0;
        base_cyc   = `MCE_CYC_ONE;
        push       = 1'b0;
        pop        = 1'b0;
        table_high_byte_we    = 1'b0;
        table_high_byte_wd    = table_high_byte;
        halt       = 1'b0;
        wdt_clr    = 1'b0;
        next_rec1  = rec1;
        next_rec2  = rec2;
        unique case (ins.op)
            MCE_JMP: begin
                base_cyc = `MCE_CYC_TWO;
                next_pc  = ins.arg[PC_W-1:0];
            end
            MCE_CALL: begin
                base_cyc = `MCE_CYC_TWO;
                push     = 1'b1;
                next_pc  = ins.arg[PC_W-1:0];
            end
            MCE_RET, MCE_RETURN_FROM_INTERRUPT: begin
                base_cyc = `MCE_CYC_TWO;
                pop      = 1'b1;
                next_pc  = stack[sp_dec];
            end
            MCE_RETA: begin
                base_cyc = `MCE_CYC_TWO;
                pop      = 1'b1;
                next_pc  = stack[sp_dec];
                acc_we   = 1'b1;
                next_acc = imm;
            end
            MCE_SZ:   skip = (mval == 8'h00);
            MCE_SZA: begin
                skip     = (mval == 8'h00);
                acc_we   = 1'b1;
                next_acc = mval;
            end
            MCE_SZB:  skip = ~bit_v;
            MCE_SNZB: skip = bit_v;
            MCE_SIZ, MCE_SDZ: begin
                mem_we = 1'b1;
                mem_wd = (ins.op == MCE_SIZ) ? inc_v : dec_v;
                skip   = (mem_wd == 8'h00);
            end
            MCE_INC_SKIP_ZERO_TO_ACC, MCE_DEC_SKIP_ZERO_TO_ACC: begin
                acc_we   = 1'b1;
                next_acc = (ins.op == MCE_INC_SKIP_ZERO_TO_ACC) ? inc_v : dec_v;
                skip     = (next_acc == 8'h00);
            end
            MCE_TRDC, MCE_TRDL: begin
                base_cyc = `MCE_CYC_TWO;
                mem_we   = 1'b1;
                mem_wd   = pmem[(ins.op == MCE_TRDC) ? tab_cur : tab_last][7:0];
                table_high_byte_we  = 1'b1;
                table_high_byte_wd  = pmem[(ins.op == MCE_TRDC) ? tab_cur : tab_last][15:8];
            end
            MCE_CLRM: begin
                mem_we = 1'b1;
                mem_wd = 8'h00;
            end
            MCE_SETM: begin
                mem_we = 1'b1;
                mem_wd = 8'hff;
            end
            MCE_CLRB: begin
                mem_we = 1'b1;
                mem_wd = mval & ~bit_msk;
            end
            MCE_CLRWD: begin
                wdt_clr   = 1'b1;
                next_flags.timeout_flag   = 1'b0;
                next_flags.powerdown_flag = 1'b0;
                next_rec1 = 1'b0;
                next_rec2 = 1'b0;
            end
            MCE_WDPRE1, MCE_WDPRE2: begin
                if ((ins.op == MCE_WDPRE1) ? rec2 : rec1) begin
                    wdt_clr   = 1'b1;
                    next_flags.timeout_flag   = 1'b0;
                    next_flags.powerdown_flag = 1'b0;
                    next_rec1 = 1'b0;
                    next_rec2 = 1'b0;
                end else if (ins.op == MCE_WDPRE1) begin
                    next_rec1 = 1'b1;
                end else begin
                    next_rec2 = 1'b1;
                end
            end
            MCE_SWAP: begin
                mem_we = 1'b1;
                mem_wd = swp_v;
            end
            MCE_NIBBLE_SWAP_TO_ACC: begin
                acc_we   = 1'b1;
                next_acc = swp_v;
            end
            MCE_HALT: begin
                halt      = 1'b1;
                wdt_clr   = 1'b1;
                next_flags.powerdown_flag = 1'b1;
                next_flags.timeout_flag   = 1'b0;
            end
            MCE_ADC, MCE_ADD, MCE_ADDI, MCE_ADD_CARRY_TO_MEMORY, MCE_ADD_TO_MEMORY: begin
                if ((ins.op == MCE_ADD_CARRY_TO_MEMORY) | (ins.op == MCE_ADD_TO_MEMORY)) begin
                    mem_we = 1'b1;
                    mem_wd = sum9[7:0];
                end else begin
                    acc_we   = 1'b1;
                    next_acc = sum9[7:0];
                end
                next_flags.carry_flag     = sum9[8];
                next_flags.aux_carry_flag = nib5[4];
                next_flags.overflow_flag  = add_ov;
                next_flags.zero_flag      = (sum9[7:0] == 8'h00);
            end
            MCE_ANDA, MCE_ANDI, MCE_AND_TO_MEMORY: begin
                if (ins.op == MCE_AND_TO_MEMORY) begin
                    mem_we = 1'b1;
                    mem_wd = and_res;
                end else begin
                    acc_we   = 1'b1;
                    next_acc = and_res;
                end
                next_flags.zero_flag = (and_res == 8'h00);
            end
            default: ;
        endcase
        if (skip) begin
            next_pc = pc + PC_W'(2);
        end
        if (mem_we & m_is_pcl) begin
            next_pc = {pc[PC_W-1:8], mem_wd};
        end
    end

    wire              pcl_hit  = mem_we & m_is_pcl;
    wire [2:0]        exec_cyc = base_cyc + {2'b00, skip} + {2'b00, pcl_hit};

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: busy for a whole number of instruction cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= MCE_IDLE;
            div      <= 2'h0;
            cyc_left <= 3'h0;
            cyc_last <= 3'h0;
            ins_q    <= '0;
        end else begin
            div <= (go | (state == MCE_HALTED)) ? 2'h0 : div + 2'h1;
            unique case (state)
                MCE_IDLE: if (go) begin
                    ins_q    <= ins;
                    cyc_last <= exec_cyc;
                    cyc_left <= exec_cyc;
                    state    <= MCE_BUSY;
                end
                MCE_BUSY: if (tick) begin
                    cyc_left <= cyc_left - 3'h1;
                    if (cyc_left == 3'h1) begin
                        state <= (ins_q.op == MCE_HALT) ? MCE_HALTED : MCE_IDLE;
                    end
                end
                MCE_HALTED: if (wr_ctrl & pwdata[`MCE_CTRL_WAKE]) begin
                    state <= MCE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog counter with prescaler
    wire              wdt_run  = wdt_en & (state != MCE_HALTED) & tick;
    wire              pre_wrap = wdt_run & (&wdt_pre);
    wire              wdt_to   = pre_wrap & (&watchdog_counter);
    wire              wdt_zero = go & wdt_clr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_pre          <= '0;
            watchdog_counter <= '0;
        end else if (wdt_zero) begin
            wdt_pre          <= '0;
            watchdog_counter <= '0;
        end else if (wdt_run) begin
            wdt_pre          <= wdt_pre + WDT_PRE_W'(1);
            watchdog_counter <= watchdog_counter + WDT_W'(pre_wrap);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Architectural registers
    mce_flags_t       flags_upd;
    always_comb begin
        flags_upd = go ? next_flags : flags;
        if (wdt_to) begin
            flags_upd.timeout_flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags           <= '0;
            acc             <= `MCE_ACC_RST;
            pc              <= `MCE_PC_RST;
            table_high_byte <= 8'h00;
            rec1            <= 1'b0;
            rec2            <= 1'b0;
            sp              <= '0;
        end else begin
            flags <= flags_upd;
            if (go) begin
                pc              <= next_pc;
                acc             <= acc_we ? next_acc : acc;
                table_high_byte <= table_high_byte_we ? table_high_byte_wd : table_high_byte;
                rec1            <= next_rec1;
                rec2            <= next_rec2;
                sp              <= push ? sp + SP_W'(1) : (pop ? sp_dec : sp);
            end else begin
                acc <= wr_acc ? pwdata[7:0] : acc;
                pc  <= wr_pc ? pwdata[PC_W-1:0] : pc;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_ptr <= 8'h00;
            dm_ptr  <= '0;
            pm_ptr  <= '0;
            wdt_en  <= 1'b0;
        end else begin
            tbl_ptr <= wr_tblp ? pwdata[7:0] : tbl_ptr;
            dm_ptr  <= wr_daddr ? pwdata[DM_AW-1:0] : dm_ptr;
            pm_ptr  <= wr_paddr ? pwdata[PM_AW-1:0] : pm_ptr;
            wdt_en  <= wr_ctrl ? pwdata[`MCE_CTRL_WDTEN] : wdt_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Memories
    always_ff @(posedge pclk) begin
        if (go & mem_we & ~m_is_pcl) begin
            dmem[maddr] <= mem_wd;
        end else if (wr_ddata) begin
            dmem[dm_ptr] <= pwdata[7:0];
        end
        if (wr_pdata) begin
            pmem[pm_ptr] <= pwdata[15:0];
        end
        if (go & push) begin
            stack[sp] <= pc_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB read mux, one access cycle, registered answer
    logic [31:0]      rd_data;
    logic             rd_err;
    wire [7:0]        dm_rd = (dm_ptr == `MCE_PCL_ADDR) ? pc[7:0] : dmem[dm_ptr];

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        unique case (paddr)
            `MCE_REG_CMD:    rd_data = ins_q;
            `MCE_REG_STATUS: rd_data = {22'h000000, rec2, rec1, flags,
                                        state == MCE_HALTED, state == MCE_BUSY};
            `MCE_REG_ACC:    rd_data = {24'h000000, acc};
            `MCE_REG_PC:     rd_data = 32'(pc);
            `MCE_REG_TABLE_HIGH_BYTE:   rd_data = {24'h000000, table_high_byte};
            `MCE_REG_TBLP:   rd_data = {24'h000000, tbl_ptr};
            `MCE_REG_DADDR:  rd_data = 32'(dm_ptr);
            `MCE_REG_DDATA:  rd_data = {24'h000000, dm_rd};
            `MCE_REG_PADDR:  rd_data = 32'(pm_ptr);
            `MCE_REG_PDATA:  rd_data = {16'h0000, pmem[pm_ptr]};
            `MCE_REG_WDT:    rd_data = 32'(watchdog_counter);
            `MCE_REG_CYCLES: rd_data = {29'h00000000, cyc_last};
            `MCE_REG_CTRL:   rd_data = {30'h00000000, wdt_en, 1'b0};
            `MCE_REG_STACK:  rd_data = 32'(sp);
            default:         rd_err  = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_data : 32'h0000_0000;
            pslverr <= psel & ~penable & rd_err;
        end
    end

endmodule

// ==== bench/mce_core_sva.sv ====
// APB port checks for the execution core
`timescale 1ns/1ps
module mce_core_sva (
    // Clock, reset and bus
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_one_pulse: assert property (pready |=> !pready) else $error("ready held");
    chk_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
    chk_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("rdata");
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
    chk_err_on_unmapped: assert property (pready |-> pslverr == (paddr > 8'h34 || paddr[1:0] != 2'h0))
        else $error("error flag wrong");
    chk_cycle_count_range: assert property (pready && !pwrite && paddr == 8'h2c |-> prdata < 32'h4)
        else $error("cycle count out of range");
    chk_halt_flag_pair: assert property (pready && !pwrite && paddr == 8'h04 && prdata[1] |-> prdata[7:6] == 2'h1)
        else $error("halt flags wrong");
endmodule
bind mce_core mce_core_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata));

// ==== bench/mce_core_bench.sv ====
// Self-checking bench for the execution core over APB
`timescale 1ns/1ps
`include "mce_consts.svh"
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin err_count++; $display("mismatch %0t %h", $time, a); end end
module mce_core_bench;
    import mce_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic        rerr;
    int          err_count = 0, total_checks = 0;
    mce_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        // One idle edge so the next setup never re-drives psel in this time step
        @(posedge pclk);
    endtask
    task automatic ck(input logic [7:0] a, input logic [31:0] e);
        xf(0, a, 0);
        `CHK(r, e)
    endtask
    task automatic mem(input logic [6:0] m, input logic [7:0] v);
        xf(1, `MCE_REG_DADDR, {25'h0, m});
        xf(1, `MCE_REG_DDATA, {24'h0, v});
    endtask
    task automatic ex(input mce_op_t op, input logic [6:0] m, input logic [15:0] g, input int n);
        xf(1, `MCE_REG_CMD, {op, 3'h0, m, g});
        do xf(0, `MCE_REG_STATUS, 0); while (r[0] !== 1'b0);
        ck(`MCE_REG_CYCLES, n);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        ck(`MCE_REG_ACC, 0);
        mem(5, 8'h00);
        ex(MCE_SZ, 5, 0, 2);
        mem(5, 8'h03);
        ex(MCE_SZ, 5, 0, 1);
        mem(5, 8'hff);
        ex(MCE_SIZ, 5, 0, 2);
        ck(`MCE_REG_DDATA, 0);
        mem(5, 8'h01);
        ex(MCE_DEC_SKIP_ZERO_TO_ACC, 5, 0, 2);
        xf(1, `MCE_REG_PC, 32'h10);
        ex(MCE_CALL, 0, 16'h0123, 2);
        ck(`MCE_REG_PC, 32'h123);
        ex(MCE_RET, 0, 0, 2);
        ck(`MCE_REG_PC, 32'h11);
        ex(MCE_JMP, 0, 16'h0040, 2);
        ex(MCE_CLRM, 6, 0, 2);
        ck(`MCE_REG_PC, 0);
        xf(1, `MCE_REG_ACC, 32'h80);
        ex(MCE_ADDI, 0, 16'h0080, 1);
        ck(`MCE_REG_STATUS, 32'h34);
        xf(1, `MCE_REG_ACC, 32'h0f);
        ex(MCE_ANDI, 0, 16'h000f, 1);
        ck(`MCE_REG_STATUS, 32'h24);
        mem(9, 8'h01);
        ex(MCE_ADD_CARRY_TO_MEMORY, 9, 0, 1);
        ck(`MCE_REG_DDATA, 32'h11);
        ck(`MCE_REG_STATUS, 32'h08);
        mem(9, 8'h12);
        ex(MCE_NIBBLE_SWAP_TO_ACC, 9, 0, 1);
        ck(`MCE_REG_ACC, 32'h21);
        xf(1, `MCE_REG_PADDR, 32'h5);
        xf(1, `MCE_REG_PDATA, 32'habcd);
        xf(1, `MCE_REG_TBLP, 32'h5);
        ex(MCE_TRDC, 9, 0, 2);
        ck(`MCE_REG_TABLE_HIGH_BYTE, 32'hab);
        ck(`MCE_REG_DDATA, 32'hcd);
        ex(MCE_CLRB, 9, 0, 1);
        ck(`MCE_REG_DDATA, 32'hcc);
        ex(MCE_HALT, 0, 0, 1);
        ck(`MCE_REG_STATUS, 32'h4a);
        xf(1, `MCE_REG_CTRL, 32'h1);
        ex(MCE_WDPRE1, 0, 0, 1);
        ck(`MCE_REG_STATUS, 32'h148);
        ex(MCE_WDPRE2, 0, 0, 1);
        ck(`MCE_REG_STATUS, 32'h08);
        xf(1, `MCE_REG_CTRL, 32'h3);
        repeat (1100) @(posedge pclk);
        xf(0, `MCE_REG_WDT, 0);
        `CHK(r != 32'h0, 1'b1)
        ex(MCE_HALT, 0, 0, 1);
        ck(`MCE_REG_WDT, 0);
        xf(1, `MCE_REG_CTRL, 32'h3);
        ex(MCE_CLRWD, 0, 0, 1);
        ck(`MCE_REG_STATUS, 32'h08);
        ck(8'h40, 0);
        `CHK(rerr, 1'b1)
        $display("test core_ops done");
        complete_run();
    end
endmodule
